// ==== bench/ipf_src_model.sv ====
// Purpose: peripheral request sources facing the priority bank
// Assumes: bench sets wanted levels, model drives them after a clock edge
// Notes:   request lines are levels, low while in reset
module ipf_src_model
	import ipf_pkg::*;
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            arst_n,
	// wanted request levels
	input  wire logic [NSRC-1:0] want,
	input  wire logic            want_wd,
	// request lines
	output logic [NSRC-1:0]      src_req,
	output logic                 wd_req
);
	timeunit 1ns;
	timeprecision 1ps;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_req <= '0;
			wd_req  <= 1'b0;
		end else begin
			src_req <= want;
			wd_req  <= want_wd;
		end
	end
endmodule // ipf_src_model

// ==== bench/peripheral_irq_priority_fields_tb_top.sv ====
// Purpose: self-checking bench of the priority field bank
// Assumes: one write or read per bus cycle, levels settle in two cycles
// Notes:   expected layout kept in a table of its own
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch t=%0t %s", $time, m); end end
module peripheral_irq_priority_fields_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ipf_pkg::*;

	logic            clk;
	logic            arst_n;
	ipf_wb_req_s     wb_req;
	ipf_wb_rsp_s     wb_rsp;
	ipf_arb_s        arb;
	logic            irq;
	logic [NSRC-1:0] want;
	logic [NSRC-1:0] src_req;
	logic [NSRC-1:0] exp_v;
	logic            want_wd;
	logic            wd_req;
	logic [31:0]     rd;
	int              mismatches;
	int              checks;
	int              cycles;
	localparam int LSB_T [NSRC] = '{14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2, 0,
		14, 12, 8, 6, 4, 2, 0};
	localparam logic [7:0] ADR_T [3] = '{8'h18, 8'h1C, 8'h20};

	ipf_prio_bank i_dut (.clk(clk), .arst_n(arst_n), .wb_i(wb_req), .wb_o(wb_rsp),
		.src_req(src_req), .decoder0_watchdog_req(wd_req), .arb_o(arb), .irq(irq));
	ipf_src_model i_src (.clk(clk), .arst_n(arst_n), .want(want), .want_wd(want_wd),
		.src_req(src_req), .wd_req(wd_req));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("mismatch t=%0t timeout", $time);
			finish_test();
		end
	end

	// one classic cycle, held until ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		do begin
			@(posedge clk);
		end while (wb_rsp.ack !== 1'b1);
		rd = wb_rsp.dat;
		wb_req <= '0;
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		arst_n = 1'b0;
		wb_req = '0;
		want = '0;
		want_wd = 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		foreach (ADR_T[k]) begin
			wb(1'b0, ADR_T[k], 32'h0000_0000);
			`CHK(rd, 32'h0000_0000, "reset value")
		end
		$display("test reset done");
		wb(1'b1, 8'h18, 32'hFFFF_FFFF);
		wb(1'b0, 8'h18, 32'h0000_0000);
		`CHK(rd, 32'h0000_FFCF, "timer c/d reserved")
		wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h1C, 32'h0000_0000);
		`CHK(rd, 32'h0000_FFFF, "timer a/b/c all fields")
		wb(1'b1, 8'h20, 32'hFFFF_FFFF);
		wb(1'b0, 8'h20, 32'h0000_0000);
		`CHK(rd, 32'h0000_F3FF, "serial reserved")
		wb(1'b1, 8'h30, 32'hFFFF_FFFF);
		wb(1'b0, 8'h30, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000, "unmapped read")
		$display("test access done");
		want <= '1;
		for (int i = 0; i < NSRC; i++) begin
			for (int f = 1; f < 4; f++) begin
				foreach (ADR_T[k]) begin
					wb(1'b1, ADR_T[k], (k == (i < 7 ? 0 : (i < 15 ? 1 : 2))) ?
						(32'(f) << LSB_T[i]) : 32'h0000_0000);
				end
				settle();
				exp_v = '0;
				exp_v[i] = 1'b1;
				`CHK(arb.valid, exp_v, "only programmed source valid")
				`CHK(arb.level[i], 2'(f - 1), "decoded level")
				`CHK(arb.lvl_pend, 3'(1 << (f - 1)), "pending level")
			end
		end
		$display("test layout done");
		@(posedge clk);
		want <= '0;
		wb(1'b1, 8'h18, 32'h0000_0001);
		wb(1'b1, 8'h40, 32'h003F_FFFF);
		wb(1'b1, 8'h44, 32'h0000_0000);
		want_wd <= 1'b1;
		settle();
		exp_v = '0;
		exp_v[SRC_DEC0_HOME] = 1'b1;
		`CHK(arb.valid, exp_v, "watchdog on home line")
		`CHK(arb.level[SRC_DEC0_HOME], LVL0, "watchdog level")
		`CHK(irq, 1'b0, "masked event")
		wb(1'b0, 8'h40, 32'h0000_0000);
		`CHK(rd, 32'h0000_0040, "home status set")
		wb(1'b1, 8'h44, 32'h0000_0040);
		wb(1'b0, 8'h44, 32'h0000_0000);
		`CHK(rd, 32'h0000_0040, "mask read back")
		settle();
		`CHK(irq, 1'b1, "unmasked event")
		wb(1'b1, 8'h18, 32'h0000_0000);
		settle();
		exp_v = '0;
		`CHK(arb.valid, exp_v, "watchdog blocked when off")
		wb(1'b1, 8'h40, 32'h0000_0040);
		want_wd <= 1'b0;
		wb(1'b0, 8'h40, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000, "status cleared")
		settle();
		`CHK(irq, 1'b0, "irq after clear")
		$display("test interrupt done");
		wb(1'b1, 8'h1C, 32'h0000_FFFF);
		wb(1'b1, 8'h44, 32'h003F_FFFF);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		wb(1'b0, 8'h1C, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000, "field after reset")
		wb(1'b0, 8'h44, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000, "mask after reset")
		$display("test second reset done");
		finish_test();
	end
endmodule // peripheral_irq_priority_fields_tb_top

// ==== core/ipf_field_dec.sv ====
// Purpose: decode one two-bit priority field against its request line
// Assumes: field value already masked of reserved bits
// Notes:   purely combinational
module ipf_field_dec
	import ipf_pkg::*;
(
	// field and request
	input  wire logic [1:0] field,
	input  wire logic       req,
	// decoded
	output logic            valid,
	output logic [1:0]      level
);

	always_comb begin
		valid = req;
		level = LVL0;
		// (R1) code to level
		case (field)
			FIELD_OFF: begin
				valid = 1'b0;
			end
			FIELD_L0: begin
				level = LVL0;
			end
			FIELD_L1: begin
				level = LVL1;
			end
			FIELD_L2: begin
				level = LVL2;
			end
			default: begin
				valid = 1'b0;
			end
		endcase
	end

endmodule // ipf_field_dec

// ==== core/ipf_pkg.sv ====
// Purpose: shared constants, layouts and carriers of the priority field bank
// Assumes: wishbone classic, 32-bit data, registers in the low 16 or 22 bits
// Notes:   register byte address is four times its index
package ipf_pkg;

	// bus geometry
	localparam int unsigned WB_ADR_W = 8;
	localparam int unsigned WB_DAT_W = 32;
	localparam int unsigned WB_SEL_W = 4;
	localparam int unsigned IDX_LSB  = 2;
	localparam int unsigned IDX_W    = 6;
	localparam int unsigned REG_W    = 16;

	// register indices
	localparam logic [IDX_W-1:0] IDX_TCD  = 6'h06;
	localparam logic [IDX_W-1:0] IDX_TABC = 6'h07;
	localparam logic [IDX_W-1:0] IDX_SER  = 6'h08;
	localparam logic [IDX_W-1:0] IDX_STAT = 6'h10;
	localparam logic [IDX_W-1:0] IDX_MASK = 6'h11;

	// reset values and writable bits
	localparam logic [REG_W-1:0] PRIO_RST   = 16'h0000;
	localparam logic [REG_W-1:0] WMASK_TCD  = 16'hFFCF;
	localparam logic [REG_W-1:0] WMASK_TABC = 16'hFFFF;
	localparam logic [REG_W-1:0] WMASK_SER  = 16'hF3FF;

	// field codes and levels
	localparam logic [1:0] FIELD_OFF = 2'h0;
	localparam logic [1:0] FIELD_L0  = 2'h1;
	localparam logic [1:0] FIELD_L1  = 2'h2;
	localparam logic [1:0] FIELD_L2  = 2'h3;
	localparam logic [1:0] LVL0      = 2'h0;
	localparam logic [1:0] LVL1      = 2'h1;
	localparam logic [1:0] LVL2      = 2'h2;
	localparam int unsigned NLVL     = 3;

	// sources: 0..6 timer c/d + decoder, 7..14 timer a/b/c, 15..21 serial + timer a
	localparam int unsigned NSRC          = 22;
	localparam int unsigned SRC_TC0       = 0;
	localparam int unsigned SRC_DEC0_HOME = 6;
	localparam int unsigned SRC_TA0       = 7;
	localparam int unsigned SRC_RX_FULL   = 15;

	typedef enum logic [1:0] {
		RSEL_TCD,
		RSEL_TABC,
		RSEL_SER
	} ipf_rsel_e;

	localparam ipf_rsel_e SRC_REG [NSRC] = '{
		RSEL_TCD, RSEL_TCD, RSEL_TCD, RSEL_TCD, RSEL_TCD, RSEL_TCD, RSEL_TCD,
		RSEL_TABC, RSEL_TABC, RSEL_TABC, RSEL_TABC,
		RSEL_TABC, RSEL_TABC, RSEL_TABC, RSEL_TABC,
		RSEL_SER, RSEL_SER, RSEL_SER, RSEL_SER, RSEL_SER, RSEL_SER, RSEL_SER
	};
	localparam int unsigned SRC_LSB [NSRC] = '{
		14, 12, 10, 8, 6, 2, 0,
		14, 12, 10, 8, 6, 4, 2, 0,
		14, 12, 8, 6, 4, 2, 0
	};

	// wishbone carriers
	typedef struct packed {
		logic                cyc;
		logic                stb;
		logic                we;
		logic [WB_ADR_W-1:0] adr;
		logic [WB_SEL_W-1:0] sel;
		logic [WB_DAT_W-1:0] dat;
	} ipf_wb_req_s;

	typedef struct packed {
		logic                ack;
		logic [WB_DAT_W-1:0] dat;
	} ipf_wb_rsp_s;

	// toward arbitration
	typedef struct packed {
		logic [NSRC-1:0]       valid;
		logic [NSRC-1:0][1:0]  level;
		logic [NLVL-1:0]       lvl_pend;
	} ipf_arb_s;

endpackage

// ==== core/ipf_prio_bank.sv ====
// Purpose: priority field bank with wishbone slave and pending status
// Assumes: requests synchronous to clk, one-clock design
// Notes:   ack one cycle after request, writes land on the ack edge

// Notes on behaviour
// (R1) Field 00 disables the source, 01/10/11 give levels 0/1/2, never above 2.
// (R2) Every priority field is 00 after reset.
// (R3) Reserved bits 5:4 of timer c/d and 11:10 of serial read zero and ignore writes.
// (R4) Timer c/d register holds tc0, td3..td0 from bit 15 down, decoder index 3:2, home 1:0.
// (R5) Register at index 7 holds ta0, tb3..tb0, tc3..tc1 from bit 15 down.
// (R6) Register at index 8 holds rx full, rx error, tx idle 9:8, tx empty 7:6, ta3..ta1.
// (R7) Decoder home field covers one line raised by home transition or watchdog.
// (R8) Timer c/d register sits at index 6 and resets to zero.
// (R9) Enabled pending sources go out at their level; a disabled one never does.
module ipf_prio_bank
	import ipf_pkg::*;
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            arst_n,
	// register bus
	input  wire ipf_wb_req_s     wb_i,
	output ipf_wb_rsp_s          wb_o,
	// peripheral requests
	input  wire logic [NSRC-1:0] src_req,
	input  wire logic            decoder0_watchdog_req,
	// toward arbitration
	output ipf_arb_s             arb_o,
	output logic                 irq
);

	typedef struct packed {
		logic [REG_W-1:0]     tcd;
		logic [REG_W-1:0]     tabc;
		logic [REG_W-1:0]     ser;
		logic [NSRC-1:0]      stat;
		logic [NSRC-1:0]      mask;
		ipf_arb_s             arb;
		logic                 ack;
		logic [WB_DAT_W-1:0]  rdat;
	} ipf_state_s;

	localparam ipf_state_s ST_RST = '{
		tcd:  PRIO_RST,
		tabc: PRIO_RST,
		ser:  PRIO_RST,
		stat: '0,
		mask: '0,
		arb:  '0,
		ack:  1'b0,
		rdat: '0
	};

	ipf_state_s              st_reg;
	ipf_state_s              st_next;
	logic [REG_W-1:0]        prio_arr [3];
	logic [NSRC-1:0]         req_w;
	logic [NSRC-1:0]         dec_valid;
	logic [NSRC-1:0][1:0]    dec_level;
	logic [IDX_W-1:0]        idx;
	logic                    req_on;
	logic                    wr_take;

	// byte-lane merge of a write into a word
	function automatic logic [WB_DAT_W-1:0] wmerge(
		input logic [WB_DAT_W-1:0] old_v,
		input logic [WB_DAT_W-1:0] new_v,
		input logic [WB_SEL_W-1:0] sel
	);
		logic [WB_DAT_W-1:0] res;
		res = old_v;
		for (int b = 0; b < WB_SEL_W; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	assign idx     = wb_i.adr[IDX_LSB +: IDX_W];
	assign req_on  = wb_i.cyc && wb_i.stb;
	assign wr_take = req_on && wb_i.we && st_reg.ack;

	assign prio_arr[RSEL_TCD]  = st_reg.tcd;
	assign prio_arr[RSEL_TABC] = st_reg.tabc;
	assign prio_arr[RSEL_SER]  = st_reg.ser;

	// (R7) home and watchdog share a line
	always_comb begin
		req_w = src_req;
		req_w[SRC_DEC0_HOME] = src_req[SRC_DEC0_HOME] | decoder0_watchdog_req;
	end

	// (R4) field placement per source
	for (genvar i = 0; i < NSRC; i++) begin : g_src
		ipf_field_dec u_dec (
			.field (prio_arr[SRC_REG[i]][SRC_LSB[i] +: 2]),
			.req   (req_w[i]),
			.valid (dec_valid[i]),
			.level (dec_level[i])
		);

		// (R1) code gives level
		property p_level_code;
			@(posedge clk) disable iff (!arst_n)
			(prio_arr[SRC_REG[i]][SRC_LSB[i] +: 2] != FIELD_OFF) && req_w[i]
			|=> arb_o.valid[i]
				&& (arb_o.level[i] == 2'($past(prio_arr[SRC_REG[i]][SRC_LSB[i] +: 2]) - FIELD_L0))
				&& (arb_o.level[i] != FIELD_L2);
		endproperty
		a_level_code: assert property (p_level_code) else $error("level code wrong"); // (R1)

		// (R9) off never leaks
		property p_off_blocks;
			@(posedge clk) disable iff (!arst_n)
			(prio_arr[SRC_REG[i]][SRC_LSB[i] +: 2] == FIELD_OFF) || !req_w[i]
			|=> !arb_o.valid[i];
		endproperty
		a_off_blocks: assert property (p_off_blocks) else $error("disabled source leaked"); // (R9)

		// (R9) valid flags its level
		property p_pend_map;
			@(posedge clk) disable iff (!arst_n)
			arb_o.valid[i] |-> arb_o.lvl_pend[arb_o.level[i]];
		endproperty
		a_pend_map: assert property (p_pend_map) else $error("level pending missing"); // (R9)

		// valid rise latches status
		property p_stat_set;
			@(posedge clk) disable iff (!arst_n)
			$rose(arb_o.valid[i]) |-> st_reg.stat[i];
		endproperty
		a_stat_set: assert property (p_stat_set) else $error("status not set"); // (R9)
	end

	always_comb begin
		st_next = st_reg;

		// registered ack, one per request
		st_next.ack = req_on && !st_reg.ack;

		// read data captured as ack rises
		if (req_on && !st_reg.ack && !wb_i.we) begin
			case (idx)
				// (R8) timer c/d at index 6
				IDX_TCD:  st_next.rdat = WB_DAT_W'(st_reg.tcd);
				IDX_TABC: st_next.rdat = WB_DAT_W'(st_reg.tabc);
				IDX_SER:  st_next.rdat = WB_DAT_W'(st_reg.ser);
				IDX_STAT: st_next.rdat = WB_DAT_W'(st_reg.stat);
				IDX_MASK: st_next.rdat = WB_DAT_W'(st_reg.mask);
				default:  st_next.rdat = '0;
			endcase
		end

		// pending set wins over write-one clear
		st_next.stat = st_reg.stat;
		if (wr_take && idx == IDX_STAT) begin
			st_next.stat = st_reg.stat & ~NSRC'(wmerge('0, wb_i.dat, wb_i.sel));
		end
		st_next.stat = st_next.stat | (dec_valid & ~st_reg.arb.valid);

		// register writes on the ack edge
		if (wr_take) begin
			case (idx)
				// (R3) reserved bits forced to zero
				IDX_TCD: begin
					st_next.tcd = REG_W'(wmerge(WB_DAT_W'(st_reg.tcd), wb_i.dat, wb_i.sel))
						& WMASK_TCD;
				end
				// (R5) full-width timer a/b/c
				IDX_TABC: begin
					st_next.tabc = REG_W'(wmerge(WB_DAT_W'(st_reg.tabc), wb_i.dat, wb_i.sel))
						& WMASK_TABC;
				end
				// (R6) serial layout, gap at 11:10
				IDX_SER: begin
					st_next.ser = REG_W'(wmerge(WB_DAT_W'(st_reg.ser), wb_i.dat, wb_i.sel))
						& WMASK_SER;
				end
				IDX_MASK: begin
					st_next.mask = NSRC'(wmerge(WB_DAT_W'(st_reg.mask), wb_i.dat, wb_i.sel));
				end
				default: begin
					st_next.mask = st_reg.mask;
				end
			endcase
		end

		// (R9) registered presentation to arbitration
		st_next.arb.valid = dec_valid;
		st_next.arb.level = dec_level;
		for (int l = 0; l < NLVL; l++) begin
			st_next.arb.lvl_pend[l] = 1'b0;
			for (int s = 0; s < NSRC; s++) begin
				if (dec_valid[s] && dec_level[s] == 2'(l)) begin
					st_next.arb.lvl_pend[l] = 1'b1;
				end
			end
		end
	end

	// (R2) all fields start disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_o.ack = st_reg.ack;
	assign wb_o.dat = st_reg.rdat;
	assign arb_o    = st_reg.arb;
	assign irq      = |(st_reg.stat & st_reg.mask);

	// first edge after reset release, for checking only
	logic seen_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_reg <= 1'b0;
		end else begin
			seen_reg <= 1'b1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// (R2) fields zero after reset
	property p_reset_zero;
		!seen_reg |-> st_reg.tcd == PRIO_RST && st_reg.tabc == PRIO_RST
			&& st_reg.ser == PRIO_RST && arb_o.valid == '0;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("fields not zero at reset"); // (R2)

	// (R3) reserved bits stay zero
	property p_reserved;
		(st_reg.tcd & ~WMASK_TCD) == '0 && (st_reg.ser & ~WMASK_SER) == '0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set"); // (R3)

	// (R4) timer c0 at top
	property p_tc0_place;
		wr_take && idx == IDX_TCD && (&wb_i.sel[1:0]) && src_req[SRC_TC0]
		|=> ##1 arb_o.valid[SRC_TC0] == ($past(wb_i.dat[15:14], 2) != FIELD_OFF);
	endproperty
	a_tc0_place: assert property (p_tc0_place) else $error("timer c0 misplaced"); // (R4)

	// (R5) timer a/b/c write
	property p_tabc_write;
		wr_take && idx == IDX_TABC && (&wb_i.sel[1:0])
		|=> st_reg.tabc == $past(wb_i.dat[REG_W-1:0]);
	endproperty
	a_tabc_write: assert property (p_tabc_write) else $error("timer a/b/c write lost"); // (R5)

	// (R6) serial write masked
	property p_ser_write;
		wr_take && idx == IDX_SER && (&wb_i.sel[1:0])
		|=> st_reg.ser == ($past(wb_i.dat[REG_W-1:0]) & WMASK_SER);
	endproperty
	a_ser_write: assert property (p_ser_write) else $error("serial write wrong"); // (R6)

	// (R7) watchdog joins home
	property p_home_or;
		decoder0_watchdog_req && st_reg.tcd[1:0] != FIELD_OFF
		|=> arb_o.valid[SRC_DEC0_HOME];
	endproperty
	a_home_or: assert property (p_home_or) else $error("watchdog not on home line"); // (R7)

	// (R8) index six reads back
	property p_tcd_read;
		wb_o.ack && req_on && !wb_i.we && idx == IDX_TCD
		|-> wb_o.dat == WB_DAT_W'(st_reg.tcd);
	endproperty
	a_tcd_read: assert property (p_tcd_read) else $error("timer c/d read wrong"); // (R8)

	// request answered next cycle
	property p_ack_answer;
		req_on && !wb_o.ack |=> wb_o.ack;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acked");

	// ack lasts one cycle
	property p_ack_pulse;
		wb_o.ack |=> !wb_o.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

	// (R5) timer a/b/c read back
	property p_tabc_read;
		wb_o.ack && req_on && !wb_i.we && idx == IDX_TABC
		|-> wb_o.dat == WB_DAT_W'(st_reg.tabc);
	endproperty
	a_tabc_read: assert property (p_tabc_read) else $error("timer a/b/c read wrong"); // (R5)

	// (R6) serial read back
	property p_ser_read;
		wb_o.ack && req_on && !wb_i.we && idx == IDX_SER
		|-> wb_o.dat == WB_DAT_W'(st_reg.ser);
	endproperty
	a_ser_read: assert property (p_ser_read) else $error("serial read wrong"); // (R6)

	// (R3) reserved pairs read zero
	property p_reserved_read;
		wb_o.ack && req_on && !wb_i.we && (idx == IDX_TCD || idx == IDX_SER)
		|-> (wb_o.dat[REG_W-1:0] & ~(idx == IDX_TCD ? WMASK_TCD : WMASK_SER)) == '0;
	endproperty
	a_reserved_read: assert property (p_reserved_read) else $error("reserved read set"); // (R3)

	// upper lanes read zero
	property p_upper_zero;
		wb_o.ack && req_on && !wb_i.we |-> wb_o.dat[WB_DAT_W-1:NSRC] == '0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

	// (R4) timer c/d write lands
	property p_tcd_write;
		wr_take && idx == IDX_TCD && (&wb_i.sel[1:0])
		|=> st_reg.tcd == ($past(wb_i.dat[REG_W-1:0]) & WMASK_TCD);
	endproperty
	a_tcd_write: assert property (p_tcd_write) else $error("timer c/d write wrong"); // (R4)

	// (R2) status, mask, bus idle
	property p_reset_idle;
		!seen_reg |-> !wb_o.ack && !irq && st_reg.stat == '0
			&& st_reg.mask == '0 && arb_o.lvl_pend == '0;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle at reset"); // (R2)

	// (R9) watchdog blocked when off
	property p_wd_off;
		decoder0_watchdog_req && st_reg.tcd[1:0] == FIELD_OFF
		|=> !arb_o.valid[SRC_DEC0_HOME];
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("disabled home line leaked"); // (R9)

	// fields move only on writes
	property p_field_hold;
		!wr_take |=> $stable(st_reg.tcd) && $stable(st_reg.tabc) && $stable(st_reg.ser);
	endproperty
	a_field_hold: assert property (p_field_hold) else $error("field changed unwritten");

	c_write_tabc: cover property (wr_take && idx == IDX_TABC);
	c_read_tcd:   cover property (wb_o.ack && !wb_i.we && idx == IDX_TCD);
	c_irq_rise:   cover property ($rose(irq));
	c_level2:     cover property (arb_o.lvl_pend[LVL2]);
	c_wd_home:    cover property (decoder0_watchdog_req && arb_o.valid[SRC_DEC0_HOME]);

endmodule // ipf_prio_bank
